// file: dfg_guard.v
// Debug and flash access guard: protection state, row protection, debug gating.
//
// Functional notes
// (R01) After a factory-fresh load the flash protection state is open, with no limit on debug access.
// (R02) Firmware may move open to protected, and in protected every debug access is refused; the code still lets a debug whole-flash erase through.
// (R03) Protected returns to open only after a whole-flash erase has completed.
// (R04) Firmware may move open to kill, and in kill every debug access is refused.
// (R05) In kill an erase asked for over the debug link is refused.
// (R06) Kill is permanent and no event leads out of it.
// (R07) Debug writes and row erases to write-protected rows and debug reads of read-protected rows are refused.
// (R08) Internal system-call flash requests are always carried out whatever the protection state.
// (R09) Debug comes up enabled unless stored otherwise and only a firmware strobe disables it.
// (R10) Once disabled, debug returns only after a whole erase, protection open and a firmware enable.
// (R11) The security lockout permanently shuts the debug link, the test pin and all debug access.
// (R12) The two-wire debug link is the only path for debug and programming requests.
// (R13) Four address breakpoint comparators and two data watchpoint comparators are provided.
// (R14) Protection, row settings, debug enable and lockout are reloaded from storage before access.
// (R15) A forbidden debug request gets an error answer and never reaches the flash.
`timescale 1ns/1ps
`include "dfg_defs.vh"

module dfg_guard #(
  parameter ROWS   = 8,
  parameter ROW_W  = 3,
  parameter DATA_W = 32,
  parameter AW     = 32,
  parameter NUM_BP = 4,
  parameter NUM_WP = 2
) (
  // Clock and reset
  input  wire                   clock,
  input  wire                   rst,
  // Nonvolatile image of the protection settings
  output reg                    nv_rd_q,
  input  wire                   nv_rd_valid,
  input  wire [1:0]             nv_prot_state,
  input  wire [ROWS-1:0]        nv_row_wprot,
  input  wire [ROWS-1:0]        nv_row_rprot,
  input  wire                   nv_dbg_en,
  input  wire                   nv_secure,
  output reg                    nv_wr_q,
  // Firmware controls
  input  wire                   fw_set_locked,
  input  wire                   fw_set_kill,
  input  wire                   fw_dbg_off,
  input  wire                   fw_dbg_on,
  input  wire                   fw_secure,
  input  wire                   fw_row_we,
  input  wire [ROWS-1:0]        fw_row_wprot,
  input  wire [ROWS-1:0]        fw_row_rprot,
  // Status; all but ready_q and erased_q also form the write image for the nonvolatile store
  output reg                    ready_q,
  output reg  [1:0]             prot_state_q,
  output reg  [ROWS-1:0]        row_wprot_q,
  output reg  [ROWS-1:0]        row_rprot_q,
  output reg                    dbg_en_q,
  output reg                    secure_q,
  output reg                    erased_q,
  // Internal system-call requests
  input  wire                   sys_req,
  input  wire [1:0]             sys_op,
  input  wire [ROW_W-1:0]       sys_row,
  input  wire [DATA_W-1:0]      sys_wdata,
  output reg                    sys_ack_q,
  // Requests decoded from the debug link
  input  wire                   dbg_req,
  input  wire [1:0]             dbg_op,
  input  wire [ROW_W-1:0]       dbg_row,
  input  wire [DATA_W-1:0]      dbg_wdata,
  output reg                    dbg_ack_q,
  output reg                    dbg_err_q,
  output reg  [DATA_W-1:0]      rdata_q,
  // Flash controller
  output reg                    fl_req_q,
  output reg  [1:0]             fl_op_q,
  output reg  [ROW_W-1:0]       fl_row_q,
  output reg  [DATA_W-1:0]      fl_wdata_q,
  output reg                    fl_src_q,
  input  wire                   fl_done,
  input  wire [DATA_W-1:0]      fl_rdata,
  // Debug and test pins
  input  wire                   swclk_pin,
  input  wire                   swdio_pin_i,
  output reg                    swdio_pin_o_q,
  output reg                    swdio_pin_oe_q,
  input  wire                   test_pin,
  // Debug core side of the link
  output reg                    core_swclk_q,
  output reg                    core_swdio_q,
  input  wire                   core_swdio_o,
  input  wire                   core_swdio_oe,
  output reg                    test_en_q,
  // Breakpoint and watchpoint comparators
  input  wire [NUM_BP*AW-1:0]   bp_addr,
  input  wire [NUM_BP-1:0]      bp_en,
  input  wire [NUM_WP*AW-1:0]   wp_addr,
  input  wire [NUM_WP-1:0]      wp_en,
  input  wire [AW-1:0]          cpu_pc,
  input  wire                   cpu_pc_valid,
  input  wire [AW-1:0]          cpu_daddr,
  input  wire                   cpu_dvalid,
  output reg  [NUM_BP-1:0]      bp_hit_q,
  output reg  [NUM_WP-1:0]      wp_hit_q,
  output reg                    halt_q
);

  reg  [1:0]              st_q;
  reg                     busy_dbg_q;
  reg                     busy_erase_all_q;
  reg  [`DFG_NPIN-1:0]    pin_q;
  wire [`DFG_NPIN-1:0]    pin_raw;
  wire                    link_open;
  wire                    dbg_deny;
  reg                     chg;

  assign pin_raw = {test_pin, swdio_pin_i, swclk_pin};

  // Every pin passes three flip-flops; the filtered level only moves when the
  // second and third stage agree, so one metastable sample never reaches the core.
  genvar gp;
  generate
    for (gp = 0; gp < `DFG_NPIN; gp = gp + 1) begin : g_pin
      reg [`DFG_SYNC_LEN-1:0] sync_q;
      always @(posedge clock) begin
        if (rst) begin
          sync_q <= `DFG_SYNC_RST;
          pin_q[gp] <= 1'b0;
        end else begin
          sync_q <= {sync_q[`DFG_SYNC_LEN-2:0], pin_raw[gp]};
          if (sync_q[`DFG_SYNC_S2] == sync_q[`DFG_SYNC_S3]) begin
            pin_q[gp] <= sync_q[`DFG_SYNC_S3];
          end
        end
      end
    end
  endgenerate

  // The link stays shut until the stored settings are loaded.
  assign link_open = ready_q & dbg_en_q & ~secure_q;  // see (R09) see (R11) see (R14)

  // Permission check for a request arriving from the debug link.
  assign dbg_deny = ~link_open
                  | (prot_state_q == `DFG_PROT_KILL)                        // see (R04) see (R05)
                  | ((prot_state_q == `DFG_PROT_LOCKED)
                     & (dbg_op != `DFG_OP_ERASE_ALL))                       // see (R02)
                  | ((dbg_op == `DFG_OP_READ) & row_rprot_q[dbg_row])       // see (R07)
                  | (((dbg_op == `DFG_OP_WRITE) | (dbg_op == `DFG_OP_ERASE_ROW))
                     & row_wprot_q[dbg_row]);                               // see (R07)

  // The store is rewritten in the cycle after any stored setting changes.
  always @* begin
    chg = 1'b0;
    if ((st_q == `DFG_ST_BUSY) && fl_done && busy_erase_all_q
        && (prot_state_q == `DFG_PROT_LOCKED)) begin
      chg = 1'b1;
    end
    if (ready_q && (((prot_state_q == `DFG_PROT_OPEN) && (st_q != `DFG_ST_BUSY)
                     && (fw_set_kill || fw_set_locked))
                    || (fw_row_we && (st_q != `DFG_ST_BUSY)) || fw_dbg_off
                    || (fw_dbg_on && erased_q && (prot_state_q == `DFG_PROT_OPEN))
                    || (fw_secure && !secure_q))) begin
      chg = 1'b1;
    end
  end

  // Link and test pins are gated each cycle, so a lockout shuts them one clock after secure_q sets.
  always @(posedge clock) begin
    if (rst) begin
      core_swclk_q   <= 1'b0;
      core_swdio_q   <= 1'b0;
      swdio_pin_o_q  <= 1'b0;
      swdio_pin_oe_q <= 1'b0;
      test_en_q      <= 1'b0;
    end else begin
      core_swclk_q   <= link_open & pin_q[`DFG_PIN_SWCLK];                 // see (R12)
      core_swdio_q   <= link_open & pin_q[`DFG_PIN_SWDIO];                 // see (R12)
      swdio_pin_o_q  <= link_open & core_swdio_o;
      swdio_pin_oe_q <= link_open & core_swdio_oe;
      test_en_q      <= ready_q & ~secure_q & pin_q[`DFG_PIN_TEST];        // see (R11)
    end
  end

  // Comparators; a hit halts the core only while debug is allowed.
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BP; gb = gb + 1) begin : g_bp
      always @(posedge clock) begin
        if (rst) begin
          bp_hit_q[gb] <= 1'b0;
        end else begin
          bp_hit_q[gb] <= link_open & bp_en[gb] & cpu_pc_valid
                          & (cpu_pc == bp_addr[gb*AW +: AW]);              // see (R13)
        end
      end
    end
    for (gb = 0; gb < NUM_WP; gb = gb + 1) begin : g_wp
      always @(posedge clock) begin
        if (rst) begin
          wp_hit_q[gb] <= 1'b0;
        end else begin
          wp_hit_q[gb] <= link_open & wp_en[gb] & cpu_dvalid
                          & (cpu_daddr == wp_addr[gb*AW +: AW]);           // see (R13)
        end
      end
    end
  endgenerate

  always @(posedge clock) begin
    if (rst) begin
      halt_q <= 1'b0;
    end else begin
      halt_q <= (|bp_hit_q) | (|wp_hit_q);
    end
  end

  // Main controller: load, arbitration, protection state.
  always @(posedge clock) begin
    if (rst) begin
      st_q             <= `DFG_ST_LOAD;
      nv_rd_q          <= 1'b0;
      nv_wr_q          <= 1'b0;
      ready_q          <= 1'b0;
      prot_state_q     <= `DFG_PROT_OPEN;                                  // see (R01)
      row_wprot_q      <= {ROWS{1'b0}};
      row_rprot_q      <= {ROWS{1'b0}};
      dbg_en_q         <= 1'b0;
      secure_q         <= 1'b1;
      erased_q         <= 1'b0;
      sys_ack_q        <= 1'b0;
      dbg_ack_q        <= 1'b0;
      dbg_err_q        <= 1'b0;
      rdata_q          <= {DATA_W{1'b0}};
      fl_req_q         <= 1'b0;
      fl_op_q          <= `DFG_OP_READ;
      fl_row_q         <= {ROW_W{1'b0}};
      fl_wdata_q       <= {DATA_W{1'b0}};
      fl_src_q         <= `DFG_SRC_INTERNAL;
      busy_dbg_q       <= 1'b0;
      busy_erase_all_q <= 1'b0;
    end else begin
      sys_ack_q <= 1'b0;
      dbg_ack_q <= 1'b0;
      dbg_err_q <= 1'b0;
      fl_req_q  <= 1'b0;
      nv_rd_q   <= 1'b0;
      case (st_q)
        `DFG_ST_LOAD: begin
          // Secure and disabled until the stored image arrives.
          nv_rd_q <= ~nv_rd_valid;
          if (nv_rd_valid) begin
            prot_state_q <= nv_prot_state;                                 // see (R14)
            row_wprot_q  <= nv_row_wprot;
            row_rprot_q  <= nv_row_rprot;
            dbg_en_q     <= nv_dbg_en;                                     // see (R09)
            secure_q     <= nv_secure;
            ready_q      <= 1'b1;
            st_q         <= `DFG_ST_IDLE;
          end
        end
        `DFG_ST_IDLE: begin
          if (sys_req) begin
            // Internal code wins arbitration and is never checked.
            fl_req_q   <= 1'b1;                                            // see (R08)
            fl_op_q    <= sys_op;
            fl_row_q   <= sys_row;
            fl_wdata_q <= sys_wdata;
            fl_src_q   <= `DFG_SRC_INTERNAL;
            busy_dbg_q <= 1'b0;
            busy_erase_all_q <= (sys_op == `DFG_OP_ERASE_ALL);
            st_q       <= `DFG_ST_BUSY;
          end else if (dbg_req) begin
            if (dbg_deny) begin
              dbg_ack_q <= 1'b1;                                           // see (R15)
              dbg_err_q <= 1'b1;
            end else begin
              fl_req_q   <= 1'b1;
              fl_op_q    <= dbg_op;
              fl_row_q   <= dbg_row;
              fl_wdata_q <= dbg_wdata;
              fl_src_q   <= `DFG_SRC_DEBUG;
              busy_dbg_q <= 1'b1;
              busy_erase_all_q <= (dbg_op == `DFG_OP_ERASE_ALL);
              st_q       <= `DFG_ST_BUSY;
            end
          end
        end
        `DFG_ST_BUSY: begin
          if (fl_done) begin
            rdata_q   <= fl_rdata;
            dbg_ack_q <= busy_dbg_q;
            sys_ack_q <= ~busy_dbg_q;
            st_q      <= `DFG_ST_IDLE;
            if (busy_erase_all_q) begin
              erased_q <= 1'b1;
              if (prot_state_q == `DFG_PROT_LOCKED) begin
                prot_state_q <= `DFG_PROT_OPEN;                            // see (R03)
                row_wprot_q  <= {ROWS{1'b0}};
                row_rprot_q  <= {ROWS{1'b0}};
              end
            end
          end
        end
        default: begin
          st_q <= `DFG_ST_LOAD;
        end
      endcase

      // Firmware strobes act only once loaded; kill never leaves.
      if (ready_q) begin
        if (prot_state_q == `DFG_PROT_OPEN && st_q != `DFG_ST_BUSY) begin
          if (fw_set_kill) begin
            prot_state_q <= `DFG_PROT_KILL;                                // see (R04) see (R06)
          end else if (fw_set_locked) begin
            prot_state_q <= `DFG_PROT_LOCKED;                              // see (R02)
          end
        end
        if (fw_row_we && st_q != `DFG_ST_BUSY) begin
          row_wprot_q <= fw_row_wprot;                                     // see (R07)
          row_rprot_q <= fw_row_rprot;
        end
        if (fw_dbg_off) begin
          dbg_en_q <= 1'b0;                                                // see (R09)
          // An erase finishing in the same cycle still counts, so set wins.
          erased_q <= (st_q == `DFG_ST_BUSY) & fl_done & busy_erase_all_q;
        end else if (fw_dbg_on && erased_q && prot_state_q == `DFG_PROT_OPEN) begin
          dbg_en_q <= 1'b1;                                                // see (R10)
        end
        if (fw_secure && !secure_q) begin
          secure_q <= 1'b1;                                                // see (R11)
        end
      end
      nv_wr_q <= chg;                                                      // see (R14)
    end
  end

endmodule // dfg_guard

// file: dfg_defs.vh
// Constants for the debug and flash access guard.
`ifndef DFG_DEFS_VH
`define DFG_DEFS_VH

// Flash protection states.
`define DFG_PROT_OPEN      2'h0
`define DFG_PROT_LOCKED    2'h1
`define DFG_PROT_KILL      2'h2

// Flash operation codes.
`define DFG_OP_READ        2'h0
`define DFG_OP_WRITE       2'h1
`define DFG_OP_ERASE_ROW   2'h2
`define DFG_OP_ERASE_ALL   2'h3

// Source of a flash operation.
`define DFG_SRC_INTERNAL   1'h0
`define DFG_SRC_DEBUG      1'h1

// Controller states.
`define DFG_ST_LOAD        2'h0
`define DFG_ST_IDLE        2'h1
`define DFG_ST_BUSY        2'h2

// Pin synchroniser depth and stage positions.
`define DFG_SYNC_LEN       3
`define DFG_SYNC_S2        1
`define DFG_SYNC_S3        2

// Number of synchronised pins and their positions.
`define DFG_NPIN           3
`define DFG_PIN_SWCLK      0
`define DFG_PIN_SWDIO      1
`define DFG_PIN_TEST       2

// Reset values.
`define DFG_PIN_RST        3'h0
`define DFG_SYNC_RST       3'h0
`define DFG_BP_RST         4'h0
`define DFG_WP_RST         2'h0

`endif

// file: dfg_guard_asserts.sv
// Port-level checks for the debug and flash access guard.
`timescale 1ns/1ps
`include "dfg_defs.vh"
module dfg_guard_asserts (
  // Clock and reset
  input wire       clock,
  input wire       rst,
  // Watched ports
  input wire       nv_wr_q,
  input wire       fw_set_kill,
  input wire       ready_q,
  input wire [1:0] prot_state_q,
  input wire       dbg_en_q,
  input wire       secure_q,
  input wire       dbg_ack_q,
  input wire       dbg_err_q,
  input wire       sys_ack_q,
  input wire       fl_req_q,
  input wire [1:0] fl_op_q,
  input wire       fl_src_q,
  input wire       fl_done,
  input wire       core_swclk_q,
  input wire       test_en_q
);
  // Protection and row strobes are refused while busy, so the kill check must know the busy span.
  reg busy_q;
  always @(posedge clock) begin
    if (rst || fl_done)
      busy_q <= 1'b0;
    else if (fl_req_q)
      busy_q <= 1'b1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_kill_req;
    ready_q && fw_set_kill && prot_state_q == `DFG_PROT_OPEN && !busy_q && !fl_req_q;
  endsequence
  sequence s_kill_done;
    prot_state_q == `DFG_PROT_KILL && nv_wr_q;
  endsequence
  kill_set_a:
    assert property (s_kill_req |=> s_kill_done) else $error("kill strobe lost");
  kill_stuck_a:
    assert property (prot_state_q == `DFG_PROT_KILL |=> prot_state_q == `DFG_PROT_KILL)
      else $error("kill state left");
  dbg_gate_a:
    assert property (fl_req_q && fl_src_q |-> $past(prot_state_q) == `DFG_PROT_OPEN
      || $past(prot_state_q) == `DFG_PROT_LOCKED && fl_op_q == `DFG_OP_ERASE_ALL)
      else $error("debug access in guarded state");
  link_off_a:
    assert property (fl_req_q && fl_src_q |-> $past(dbg_en_q) && !$past(secure_q))
      else $error("debug access with link off");
  sys_done_a:
    assert property (fl_done && !fl_src_q |=> sys_ack_q) else $error("no system ack");
  dbg_done_a:
    assert property (fl_done && fl_src_q |=> dbg_ack_q && !dbg_err_q) else $error("no debug ack");
  err_ack_a:
    assert property (dbg_err_q |-> dbg_ack_q && !busy_q && !fl_req_q) else $error("bad refusal");
  load_block_a:
    assert property (!ready_q |-> !fl_req_q && !dbg_ack_q && !core_swclk_q)
      else $error("access before load");
  secure_pins_a:
    assert property (secure_q && $past(secure_q) |-> !core_swclk_q && !test_en_q)
      else $error("pins open under lockout");
endmodule // dfg_guard_asserts

bind dfg_guard dfg_guard_asserts u_chk (
  .clock(clock), .rst(rst), .nv_wr_q(nv_wr_q), .fw_set_kill(fw_set_kill),
  .ready_q(ready_q), .prot_state_q(prot_state_q), .dbg_en_q(dbg_en_q),
  .secure_q(secure_q), .dbg_ack_q(dbg_ack_q), .dbg_err_q(dbg_err_q),
  .sys_ack_q(sys_ack_q), .fl_req_q(fl_req_q), .fl_op_q(fl_op_q), .fl_src_q(fl_src_q),
  .fl_done(fl_done), .core_swclk_q(core_swclk_q), .test_en_q(test_en_q)
);

// file: dfg_flash_model.sv
// Flash array and settings store facing the access guard.
`timescale 1ns/1ps
`include "dfg_defs.vh"
module dfg_flash_model (
  // Clock, reset and answer delay
  input  wire        clock,
  input  wire        rst,
  input  wire [3:0]  dly,
  // Settings store
  input  wire        nv_rd_q,
  input  wire        nv_wr_q,
  input  wire [19:0] img_in,
  output reg         nv_rd_valid,
  output wire [19:0] img_out,
  // Flash array
  input  wire        fl_req_q,
  input  wire [1:0]  fl_op_q,
  input  wire [2:0]  fl_row_q,
  input  wire [31:0] fl_wdata_q,
  output reg         fl_done,
  output wire [31:0] fl_rdata
);
  reg [19:0] img_q = 20'h00002;
  reg [31:0] mem [0:7];
  reg [31:0] rd_q = 32'h0;
  reg [3:0]  cnt_q = 4'h0;
  integer    i;
  initial for (i = 0; i < 8; i = i + 1) mem[i] = 32'h0;
  // Lines outside an answer show the inverse, so a stale value never passes.
  assign img_out  = nv_rd_valid ? img_q : ~img_q;
  assign fl_rdata = fl_done ? rd_q : ~rd_q;
  always @(posedge clock) begin
    nv_rd_valid <= nv_rd_q && !rst;
    fl_done <= 1'b0;
    if (nv_wr_q) img_q <= img_in;
    if (rst) cnt_q <= 4'h0;
    else if (fl_req_q) cnt_q <= dly;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    if (cnt_q == 4'h1) begin
      fl_done <= 1'b1;
      rd_q <= mem[fl_row_q];
      if (fl_op_q == `DFG_OP_WRITE) mem[fl_row_q] <= fl_wdata_q;
      if (fl_op_q == `DFG_OP_ERASE_ROW) mem[fl_row_q] <= 32'h0;
      if (fl_op_q == `DFG_OP_ERASE_ALL) for (i = 0; i < 8; i = i + 1) mem[i] <= 32'h0;
    end
  end
endmodule // dfg_flash_model

// file: testbench.sv
// Self-checking bench for the debug and flash access guard.
`timescale 1ns/1ps
`include "dfg_defs.vh"
module testbench;
  reg          clock = 1'b0;
  reg          rst = 1'b1;
  reg  [5:0]   fw = 6'h00;
  reg  [7:0]   wmask = 8'h00, rmask = 8'h00;
  reg          sreq = 1'b0, dreq = 1'b0, pv = 1'b0, pcv = 1'b0;
  reg  [1:0]   op = 2'h0;
  reg  [2:0]   row = 3'h0;
  reg  [31:0]  wd = 32'h0, pc = 32'h0, r;
  reg  [127:0] bpa = 128'h0;
  reg  [63:0]  wpa = 64'h0;
  reg  [5:0]   cen = 6'h00;
  reg  [3:0]   dly = 4'h1;
  wire         nvr, nvv, nvw, rdy, den, sec, sak, dak, der, frq, fdn, ckq, dioq, tstq;
  wire [1:0]   pst, fop, wph;
  wire [7:0]   wpq, rpq;
  wire [2:0]   frow;
  wire [31:0]  rdq, fwd, frd;
  wire [19:0]  imo;
  wire [3:0]   bph;
  wire         sdo, soe, hlt, ers, fsrc;
  reg  [1:0]   st;
  reg  [7:0]   wm, rm;
  reg          de, se, er;
  integer      mem [0:7];
  integer      seed, errors, samples_checked, i;
  always #12.5 clock = ~clock;
  dfg_guard u_dut (.clock(clock), .rst(rst), .nv_rd_q(nvr), .nv_rd_valid(nvv),
    .nv_prot_state(imo[19:18]), .nv_row_wprot(imo[17:10]), .nv_row_rprot(imo[9:2]),
    .nv_dbg_en(imo[1]), .nv_secure(imo[0]), .nv_wr_q(nvw), .fw_set_locked(fw[0]),
    .fw_set_kill(fw[1]), .fw_dbg_off(fw[2]), .fw_dbg_on(fw[3]), .fw_secure(fw[4]),
    .fw_row_we(fw[5]), .fw_row_wprot(wmask), .fw_row_rprot(rmask), .ready_q(rdy),
    .prot_state_q(pst), .row_wprot_q(wpq), .row_rprot_q(rpq), .dbg_en_q(den),
    .secure_q(sec), .erased_q(ers), .sys_req(sreq), .sys_op(op), .sys_row(row),
    .sys_wdata(wd), .sys_ack_q(sak), .dbg_req(dreq), .dbg_op(op), .dbg_row(row),
    .dbg_wdata(wd), .dbg_ack_q(dak), .dbg_err_q(der), .rdata_q(rdq), .fl_req_q(frq),
    .fl_op_q(fop), .fl_row_q(frow), .fl_wdata_q(fwd), .fl_src_q(fsrc), .fl_done(fdn),
    .fl_rdata(frd), .swclk_pin(pv), .swdio_pin_i(pv), .swdio_pin_o_q(sdo),
    .swdio_pin_oe_q(soe), .test_pin(pv), .core_swclk_q(ckq), .core_swdio_q(dioq),
    .core_swdio_o(pv), .core_swdio_oe(pv), .test_en_q(tstq), .bp_addr(bpa),
    .bp_en(cen[3:0]), .wp_addr(wpa), .wp_en(cen[5:4]), .cpu_pc(pc), .cpu_pc_valid(pcv),
    .cpu_daddr(pc), .cpu_dvalid(pcv), .bp_hit_q(bph), .wp_hit_q(wph), .halt_q(hlt));
  dfg_flash_model u_fl (.clock(clock), .rst(rst), .dly(dly), .nv_rd_q(nvr), .nv_wr_q(nvw),
    .img_in({pst, wpq, rpq, den, sec}), .nv_rd_valid(nvv), .img_out(imo), .fl_req_q(frq),
    .fl_op_q(fop), .fl_row_q(frow), .fl_wdata_q(fwd), .fl_done(fdn), .fl_rdata(frd));
  task give_verdict(input f);
    begin
      errors = errors + f;
      $display("Checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task check_val(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task do_reset;
    integer n;
    begin
      rst <= 1'b1;
      // The erased flag is not stored, so a reset clears it.
      er = 1'b0;
      repeat (5) @(posedge clock);
      #1 rst <= 1'b0;
      for (n = 0; rdy !== 1'b1; n = n + 1) begin
        if (n == 20) give_verdict(1);
        @(posedge clock);
        #1;
      end
    end
  endtask
  // Request is dropped right after the ack lands, so it is never taken twice.
  task access(input s, input [1:0] o, input [2:0] w, input [31:0] d);
    integer n, k, ex;
    begin
      ex = s && (se || !de || st == 2 || (st == 1 && o != 3) || (o == 0 && rm[w])
        || (o[0] ^ o[1] && wm[w]));
      @(posedge clock);
      #1;
      r = $random(seed);
      dly <= {1'b0, r[2:0]} + 4'h1;
      op <= o;
      row <= w;
      wd <= d;
      if (s) dreq <= 1'b1;
      else sreq <= 1'b1;
      for (n = 0; (s ? dak : sak) !== 1'b1; n = n + 1) begin
        if (n == 40) give_verdict(1);
        @(posedge clock);
        #1;
      end
      dreq <= 1'b0;
      sreq <= 1'b0;
      check_val(der, ex);
      if (!ex) check_val(fsrc, s);
      if (!ex && o == 0) check_val(rdq, mem[w]);
      if (!ex && o == 1) mem[w] = d;
      if (!ex && o == 2) mem[w] = 0;
      if (!ex && o == 3) begin
        for (k = 0; k < 8; k = k + 1) mem[k] = 0;
        er = 1'b1;
        if (st == 1) begin
          st = 2'h0;
          wm = 8'h00;
          rm = 8'h00;
        end
      end
    end
  endtask
  task strobe(input [2:0] k);
    begin
      @(posedge clock);
      #1 fw <= 6'h01 << k;
      @(posedge clock);
      #1 fw <= 6'h00;
      if (k == 0 && st == 0) st = 2'h1;
      if (k == 1 && st == 0) st = 2'h2;
      if (k == 2) {de, er} = 2'b00;
      if (k == 3 && er && st == 0) de = 1'b1;
      if (k == 4) se = 1'b1;
      if (k == 5) {wm, rm} = {wmask, rmask};
      check_val({pst, wpq, rpq}, {st, wm, rm});
      check_val({den, sec, ers}, {de, se, er});
    end
  endtask
  task pins(input e);
    begin
      @(posedge clock);
      #1 pv <= 1'b1;
      repeat (5) @(posedge clock);
      #1 check_val({ckq, dioq, sdo, soe, tstq}, {e, e, e, e, !se});
      pv <= 1'b0;
      repeat (5) @(posedge clock);
    end
  endtask
  initial begin
    seed = 53;
    {errors, samples_checked} = 0;
    {st, de, se, er, wm, rm} = 21'h40000;
    for (i = 0; i < 8; i = i + 1) mem[i] = 0;
    do_reset;
    check_val({pst, den, sec, ers}, {st, de, se, er});
    for (i = 0; i < 16; i = i + 1) access(1, i / 8, i % 8, $random(seed));
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge clock);
      #1 r = $random(seed);
      if (i < 4) bpa[i * 32 +: 32] <= r;
      else wpa[(i - 4) * 32 +: 32] <= r;
      {pc, pcv, cen} <= {r, 1'b1, 6'h01 << i};
      @(posedge clock);
      #1 check_val({wph, bph}, 6'h01 << i);
      pcv <= 1'b0;
      @(posedge clock);
      #1 check_val(hlt, 1'b1);
    end
    pins(1);
    $display("Test open done");
    {wmask, rmask} <= 16'h0420;
    strobe(5);
    access(1, 1, 2, 32'h5A5A5A5A);
    access(1, 2, 2, 32'h0);
    access(1, 0, 5, 32'h0);
    access(1, 0, 2, 32'h0);
    access(0, 1, 2, $random(seed));
    access(0, 0, 5, 32'h0);
    $display("Test rows done");
    strobe(2);
    access(1, 0, 0, 32'h0);
    pins(0);
    strobe(3);
    access(0, 3, 0, 32'h0);
    strobe(3);
    access(1, 0, 1, 32'h0);
    $display("Test debug off done");
    strobe(0);
    access(1, 0, 3, 32'h0);
    access(1, 1, 3, 32'h1);
    access(0, 1, 3, $random(seed));
    access(1, 3, 0, 32'h0);
    check_val({pst, wpq, rpq}, {st, wm, rm});
    $display("Test locked done");
    strobe(1);
    access(1, 3, 0, 32'h0);
    access(1, 1, 0, 32'h2);
    strobe(0);
    access(0, 1, 6, $random(seed));
    do_reset;
    check_val({pst, den, sec, wpq, rpq}, {st, de, se, wm, rm});
    access(0, 0, 6, 32'h0);
    $display("Test kill done");
    strobe(4);
    pins(0);
    access(1, 0, 6, 32'h0);
    $display("Test lockout done");
    give_verdict(0);
  end
endmodule // testbench
